// ==== src/csr_regs.sv ====
// Status and reset-control register bank of the charger, with its management bus slave.
// Assumes comparator inputs and bus pins are already synchronous to i_clk; the data pin
// is open drain and resolved outside from o_smb_data_oe.
`timescale 1ns/1ns
module csr_regs
  import csr_pkg::*;
#(
  parameter int P_TICK_CYCLES = CSR_TICK_CYCLES,
  parameter int P_SCP_TICKS = CSR_SCP_TICKS,
  parameter int P_OTP_CYCLES = CSR_OTP_LOAD_CYCLES,
  parameter logic [6:0] P_DEV_ADDR = CSR_DEV_ADDR
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire csr_sense_t i_sense,
  input wire logic i_usb_bus_input_enable,
  input wire logic i_adapter_input_enable,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  output logic o_smb_data_out,
  output logic o_smb_data_oe,
  output logic o_converter_run,
  output logic o_charge_run,
  output logic o_otp_load_busy,
  output csr_rst_req_t o_rst_req
);

  logic tick;
  logic scp_expired;
  logic bshort_expired;
  logic [15:0] ctrl_r;
  logic [15:0] watch_r;
  logic wr_en_r;
  logic [7:0] wr_addr_r;
  logic [15:0] wr_data_r;
  logic otp_busy_r;
  logic otp_done_r;
  logic [15:0] otp_cnt_r;
  logic scp_latch_r;
  logic any_input_q;
  logic bat_short_r;
  logic bat_ov_r;
  logic adp_lim_r;
  logic usb_lim_r;
  logic any_input;
  logic adp_ovp_sel;
  logic adp_clps_sel;
  logic alarm_clr;
  logic det_hold;
  logic [15:0] bat_rail_w;
  logic [15:0] input_w;
  logic [15:0] sys_status_w;
  logic [8:0] watch_limit;

  csr_tick_div #(
    .P_CYCLES(P_TICK_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(tick)
  );

  csr_persist #(
    .P_W(9)
  ) u_scp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_cond(i_sense.sys_below_uvlo),
    .i_limit(9'(P_SCP_TICKS)),
    .o_expired(scp_expired)
  );

  // Strictly longer than the programmed period, hence one extra tick
  assign watch_limit = {1'b0, watch_r[CSR_WATCH_LSB +: 8]} + 9'h001;

  csr_persist #(
    .P_W(9)
  ) u_bshort (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_cond(i_sense.bat_short_cmp),
    .i_limit(watch_limit),
    .o_expired(bshort_expired)
  );

  // Control register and reset requests
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= CSR_CTRL_RESET;
      watch_r <= CSR_WATCH_RESET;
    end else if (wr_en_r) begin
      if (wr_addr_r == CSR_OFF_SYS_CTRL) begin
        ctrl_r <= wr_data_r;
        ctrl_r[CSR_B_OTP] <= 1'b0;
      end
      if (wr_addr_r == CSR_OFF_WATCH) begin
        watch_r <= wr_data_r;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rst_req <= '0;
    end else begin
      o_rst_req.measure_status_reset <= ctrl_r[CSR_B_MEAS_RST];
      o_rst_req.alarm_status_reset <= ctrl_r[CSR_B_ALARM_RST];
      o_rst_req.charge_detect_reset <= ctrl_r[CSR_B_CHG_RST];
      o_rst_req.global_register_reset <= ctrl_r[CSR_B_GLOBAL_RST];
    end
  end

  // Load runs once after reset and again on each start request
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      otp_busy_r <= 1'b1;
      otp_done_r <= 1'b0;
      otp_cnt_r <= 16'h0;
    end else if (wr_en_r && wr_addr_r == CSR_OFF_SYS_CTRL && wr_data_r[CSR_B_OTP]) begin
      otp_busy_r <= 1'b1;
      otp_done_r <= 1'b0;
      otp_cnt_r <= 16'h0;
    end else if (otp_busy_r) begin
      if (otp_cnt_r >= 16'(P_OTP_CYCLES - 1)) begin
        otp_busy_r <= 1'b0;
        otp_done_r <= 1'b1;
      end else begin
        otp_cnt_r <= otp_cnt_r + 16'h1;
      end
    end
  end

  assign alarm_clr = ctrl_r[CSR_B_ALARM_RST] | ctrl_r[CSR_B_GLOBAL_RST];
  assign det_hold = ctrl_r[CSR_B_CHG_RST] | ctrl_r[CSR_B_GLOBAL_RST];

  // Protection and event state
  assign any_input = i_sense.usb_above_uvlo | i_sense.adapter_above_uvlo;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      any_input_q <= 1'b0;
    end else begin
      any_input_q <= any_input;
    end
  end

  // Only an input returning clears the latch; the host resets do not, and a new
  // expiry in the same cycle wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scp_latch_r <= 1'b0;
    end else if (scp_expired) begin
      scp_latch_r <= 1'b1;
    end else if (any_input && !any_input_q) begin
      scp_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bat_short_r <= 1'b0;
    end else if (bshort_expired) begin
      bat_short_r <= 1'b1;
    end else if (alarm_clr) begin
      bat_short_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bat_ov_r <= 1'b0;
    end else if (i_sense.bat_above_ov) begin
      bat_ov_r <= 1'b1;
    end else if (i_sense.bat_below_ov_hyst) begin
      bat_ov_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      adp_lim_r <= 1'b0;
      usb_lim_r <= 1'b0;
    end else begin
      if (i_sense.adapter_limit_mod) begin
        adp_lim_r <= 1'b1;
      end else if (alarm_clr) begin
        adp_lim_r <= 1'b0;
      end
      if (i_sense.usb_limit_mod) begin
        usb_lim_r <= 1'b1;
      end else if (alarm_clr) begin
        usb_lim_r <= 1'b0;
      end
    end
  end

  // Adapter pin when enabled, sense node when both inputs are disabled
  always_comb begin
    adp_ovp_sel = 1'b0;
    adp_clps_sel = 1'b0;
    if (i_adapter_input_enable) begin
      adp_ovp_sel = i_sense.adapter_above_ovp;
      adp_clps_sel = i_sense.adapter_clps;
    end else if (!i_usb_bus_input_enable) begin
      adp_ovp_sel = i_sense.sense_above_ovp;
      adp_clps_sel = i_sense.sense_clps;
    end
  end

  // Input overvoltage and global reset stop by level; battery overvoltage holds until its hysteresis level, the short-circuit latch until an input returns
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_converter_run <= 1'b0;
      o_charge_run <= 1'b0;
      o_otp_load_busy <= 1'b0;
    end else begin
      o_converter_run <= !scp_latch_r && !bat_ov_r && !adp_ovp_sel
        && !i_sense.usb_above_ovp && !ctrl_r[CSR_B_GLOBAL_RST];
      o_charge_run <= !scp_latch_r && !bat_ov_r && !adp_ovp_sel
        && !i_sense.usb_above_ovp && !ctrl_r[CSR_B_GLOBAL_RST];
      o_otp_load_busy <= otp_busy_r;
    end
  end

  // Status words
  always_comb begin
    bat_rail_w = 16'h0000;
    bat_rail_w[CSR_B_SYS_OV] = (i_sense.sys_above_ovp && !any_input) || scp_latch_r;
    bat_rail_w[CSR_B_SYS_SSD] = i_sense.softstart_done && o_converter_run;
    bat_rail_w[CSR_B_SYS_SCP] = scp_latch_r;
    bat_rail_w[CSR_B_SYS_UV] = i_sense.sys_below_uvlo;
    bat_rail_w[CSR_B_BAT_SHORT] = bat_short_r;
    bat_rail_w[CSR_B_BAT_OV] = bat_ov_r;
    bat_rail_w[CSR_B_DEPLETED] = i_sense.bat_below_sysreg;
  end

  // Detection flags read as zero while their group is held in reset
  always_comb begin
    input_w = 16'h0000;
    if (!det_hold) begin
      input_w[CSR_B_SENSE_DET] = i_sense.sense_above_uvlo;
      input_w[CSR_B_ADP_OVP] = adp_ovp_sel;
      input_w[CSR_B_ADP_LIM] = adp_lim_r;
      input_w[CSR_B_ADP_CLPS] = adp_clps_sel;
      input_w[CSR_B_ADP_DET] = i_sense.adapter_above_uvlo;
      input_w[CSR_B_USB_OVP] = i_sense.usb_above_ovp;
      input_w[CSR_B_USB_LIM] = usb_lim_r;
      input_w[CSR_B_USB_CLPS] = i_sense.usb_clps;
      input_w[CSR_B_USB_DET] = i_sense.usb_above_uvlo;
    end
  end

  always_comb begin
    sys_status_w = 16'h0000;
    sys_status_w[CSR_B_MEAS_RST] = ctrl_r[CSR_B_MEAS_RST];
    sys_status_w[CSR_B_ALARM_RST] = ctrl_r[CSR_B_ALARM_RST];
    sys_status_w[CSR_B_CHG_RST] = ctrl_r[CSR_B_CHG_RST];
    sys_status_w[CSR_B_OTP] = otp_done_r;
    sys_status_w[CSR_B_GLOBAL_RST] = ctrl_r[CSR_B_GLOBAL_RST];
  end

  function automatic logic [15:0] read_word(input logic [7:0] addr);
    case (addr)
      CSR_OFF_BAT_RAIL: read_word = bat_rail_w;
      CSR_OFF_INPUT: read_word = input_w;
      CSR_OFF_WATCH: read_word = watch_r;
      CSR_OFF_CHGOP: read_word = sys_status_w;
      CSR_OFF_SYS_STATUS: read_word = sys_status_w;
      CSR_OFF_SYS_CTRL: read_word = ctrl_r;
      default: read_word = 16'h0000;
    endcase
  endfunction

  // Management bus slave
  // Word protocol, low byte first, most significant bit first within a byte.
  // Writes to status offsets complete on the bus but change nothing.
  csr_bus_st_t st_r;
  logic scl_q;
  logic sda_q;
  logic [3:0] bitcnt_r;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic [7:0] lo_r;
  logic [15:0] tx_r;
  logic byte_sel_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] tx_byte;

  assign scl_rise = i_smb_clk && !scl_q;
  assign scl_fall = !i_smb_clk && scl_q;
  assign bus_start = i_smb_clk && scl_q && sda_q && !i_smb_data;
  assign bus_stop = i_smb_clk && scl_q && !sda_q && i_smb_data;
  assign tx_byte = byte_sel_r ? tx_r[15:8] : tx_r[7:0];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      o_smb_data_out <= 1'b0;
    end else begin
      scl_q <= i_smb_clk;
      sda_q <= i_smb_data;
      o_smb_data_out <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      lo_r <= 8'h00;
      tx_r <= 16'h0000;
      byte_sel_r <= 1'b0;
      o_smb_data_oe <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 16'h0000;
    end else begin
      wr_en_r <= 1'b0;
      if (bus_start) begin
        st_r <= ST_ADDR;
        bitcnt_r <= 4'h0;
        o_smb_data_oe <= 1'b0;
      end else if (bus_stop) begin
        st_r <= ST_IDLE;
        o_smb_data_oe <= 1'b0;
      end else if (scl_rise && st_r != ST_IDLE) begin
        if (bitcnt_r == 4'h8) begin
          bitcnt_r <= 4'h0;
          case (st_r)
            ST_ADDR: begin
              if (sh_r[0]) begin
                st_r <= ST_RDATA;
                tx_r <= read_word(cmd_r);
              end else begin
                st_r <= ST_CMD;
              end
              byte_sel_r <= 1'b0;
            end
            ST_CMD: begin
              st_r <= ST_WDATA;
              byte_sel_r <= 1'b0;
            end
            ST_WDATA: byte_sel_r <= ~byte_sel_r;
            ST_RDATA: begin
              if (i_smb_data) begin
                st_r <= ST_IGNORE;
              end
              byte_sel_r <= 1'b1;
            end
            default: st_r <= st_r;
          endcase
        end else begin
          sh_r <= {sh_r[6:0], i_smb_data};
          bitcnt_r <= bitcnt_r + 4'h1;
        end
      end else if (scl_fall && st_r != ST_IDLE) begin
        o_smb_data_oe <= 1'b0;
        if (bitcnt_r == 4'h8) begin
          case (st_r)
            ST_ADDR: begin
              if (sh_r[7:1] == P_DEV_ADDR) begin
                o_smb_data_oe <= 1'b1;
              end else begin
                st_r <= ST_IGNORE;
              end
            end
            ST_CMD: begin
              cmd_r <= sh_r;
              o_smb_data_oe <= 1'b1;
            end
            ST_WDATA: begin
              o_smb_data_oe <= 1'b1;
              if (!byte_sel_r) begin
                lo_r <= sh_r;
              end else if (cmd_r == CSR_OFF_SYS_CTRL || cmd_r == CSR_OFF_WATCH) begin
                wr_en_r <= 1'b1;
                wr_addr_r <= cmd_r;
                wr_data_r <= {sh_r, lo_r};
              end
            end
            default: o_smb_data_oe <= 1'b0;
          endcase
        end else if (st_r == ST_RDATA) begin
          o_smb_data_oe <= !tx_byte[3'(4'h7 - bitcnt_r)];
        end
      end
    end
  end

endmodule : csr_regs

// ==== src/csr_pkg.sv ====
// Constants, field layout and carrier types for the charger status and reset register bank.
// Assumes a single 125 MHz clock and comparator results already synchronous to it.
package csr_pkg;

  // Register offsets (command codes on the management bus)
  localparam logic [7:0] CSR_OFF_BAT_RAIL = 8'h01;
  localparam logic [7:0] CSR_OFF_INPUT = 8'h02;
  localparam logic [7:0] CSR_OFF_WATCH = 8'h10;
  localparam logic [7:0] CSR_OFF_CHGOP = 8'h3b;
  localparam logic [7:0] CSR_OFF_SYS_STATUS = 8'h3c;
  localparam logic [7:0] CSR_OFF_SYS_CTRL = 8'h3d;

  // Battery and rail status fields
  localparam int CSR_B_SYS_OV = 15;
  localparam int CSR_B_SYS_SSD = 14;
  localparam int CSR_B_SYS_SCP = 13;
  localparam int CSR_B_SYS_UV = 12;
  localparam int CSR_B_BAT_SHORT = 6;
  localparam int CSR_B_BAT_OV = 3;
  localparam int CSR_B_DEPLETED = 0;
  // Input status fields
  localparam int CSR_B_SENSE_DET = 12;
  localparam int CSR_B_ADP_OVP = 11;
  localparam int CSR_B_ADP_LIM = 10;
  localparam int CSR_B_ADP_CLPS = 9;
  localparam int CSR_B_ADP_DET = 8;
  localparam int CSR_B_USB_OVP = 3;
  localparam int CSR_B_USB_LIM = 2;
  localparam int CSR_B_USB_CLPS = 1;
  localparam int CSR_B_USB_DET = 0;
  // Control and system status fields
  localparam int CSR_B_MEAS_RST = 6;
  localparam int CSR_B_ALARM_RST = 5;
  localparam int CSR_B_CHG_RST = 4;
  localparam int CSR_B_OTP = 1;
  localparam int CSR_B_GLOBAL_RST = 0;
  localparam int CSR_WATCH_LSB = 8;
  localparam logic [15:0] CSR_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CSR_WATCH_RESET = 16'h0000;

  // Timing
  localparam int CSR_CLK_PERIOD_NS = 8;
  localparam int CSR_TICK_NS = 1_000_000;
  localparam int CSR_TICK_CYCLES = CSR_TICK_NS / CSR_CLK_PERIOD_NS;
  localparam int CSR_SCP_TIME_MS = 20;
  localparam int CSR_SCP_TICKS = CSR_SCP_TIME_MS * CSR_TICK_NS / 1_000_000;
  localparam int CSR_OTP_LOAD_CYCLES = 32;

  // Arbitrary default bus address, not tied to any part
  localparam logic [6:0] CSR_DEV_ADDR = 7'h2a;

  // Comparator results from the analog front end
  typedef struct packed {
    logic sys_above_ovp;
    logic softstart_done;
    logic sys_below_uvlo;
    logic bat_short_cmp;
    logic bat_above_ov;
    logic bat_below_ov_hyst;
    logic bat_below_sysreg;
    logic sense_above_uvlo;
    logic adapter_above_ovp;
    logic sense_above_ovp;
    logic adapter_limit_mod;
    logic adapter_clps;
    logic sense_clps;
    logic adapter_above_uvlo;
    logic usb_above_ovp;
    logic usb_limit_mod;
    logic usb_clps;
    logic usb_above_uvlo;
  } csr_sense_t;

  // Reset requests handed to the neighbouring register groups
  typedef struct packed {
    logic measure_status_reset;
    logic alarm_status_reset;
    logic charge_detect_reset;
    logic global_register_reset;
  } csr_rst_req_t;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } csr_bus_st_t;

endpackage : csr_pkg

// ==== src/csr_tick_div.sv ====
// Divider that turns the system clock into a one-cycle tick enable.
// Assumes one clock domain; the period is a parameter so simulation can shorten it.
`timescale 1ns/1ns
module csr_tick_div #(
  parameter int P_CYCLES = 125000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  output logic o_tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt_r >= 32'(P_CYCLES - 1)) begin
      cnt_r <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule : csr_tick_div

// ==== src/csr_persist.sv ====
// Persistence timer: reports a condition once it has held for a number of ticks.
// Assumes the tick is a one-cycle enable; the count restarts whenever the condition drops.
`timescale 1ns/1ns
module csr_persist #(
  parameter int P_W = 9
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_cond,
  input wire logic [P_W-1:0] i_limit,
  output logic o_expired
);
  logic [P_W-1:0] cnt_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_cond) begin
      cnt_r <= '0;
    end else if (i_tick && cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_cond && (cnt_r >= i_limit);
    end
  end
endmodule : csr_persist

// ==== testbench/csr_regs_asserts.sv ====
// Port-level checks for the charger status and reset register bank.
// Bound to csr_regs from the bench top; sees only that module's ports.
`timescale 1ns/1ns
module csr_regs_asserts
  import csr_pkg::*;
#(
  parameter int P_TICK_CYCLES = 10,
  parameter int P_SCP_TICKS = 20,
  parameter int P_OTP_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire csr_sense_t i_sense,
  input wire logic i_usb_bus_input_enable,
  input wire logic i_adapter_input_enable,
  input wire logic i_smb_clk,
  input wire logic i_smb_data,
  input wire logic o_smb_data_out,
  input wire logic o_smb_data_oe,
  input wire logic o_converter_run,
  input wire logic o_charge_run,
  input wire logic o_otp_load_busy,
  input wire csr_rst_req_t o_rst_req
);
  // Slack covers the unknown phase of the tick against the start of the low rail
  localparam int SCP_LIM = P_TICK_CYCLES * (P_SCP_TICKS + 1) + 4;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] uv_cnt_r;
  logic [7:0] busy_cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_sense.sys_below_uvlo) begin
      uv_cnt_r <= 16'h0;
    end else if (uv_cnt_r != 16'hffff) begin
      uv_cnt_r <= uv_cnt_r + 16'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_otp_load_busy) begin
      busy_cnt_r <= 8'h0;
    end else if (busy_cnt_r != 8'hff) begin
      busy_cnt_r <= busy_cnt_r + 8'h1;
    end
  end
  sequence usb_ovp_held;
    i_sense.usb_above_ovp [*3];
  endsequence
  sequence adp_ovp_held;
    (i_adapter_input_enable && i_sense.adapter_above_ovp) [*3];
  endsequence
  sequence sense_ovp_held;
    (!i_usb_bus_input_enable && !i_adapter_input_enable && i_sense.sense_above_ovp) [*3];
  endsequence
  usb_ovp_stop_a: assert property (usb_ovp_held |-> !o_converter_run)
    else $error("converter runs during bus overvoltage");
  adp_ovp_stop_a: assert property (adp_ovp_held |-> !o_converter_run)
    else $error("converter runs during adapter overvoltage");
  sense_ovp_stop_a: assert property (sense_ovp_held |-> !o_converter_run)
    else $error("converter runs during sense node overvoltage");
  bat_ovp_stop_a: assert property (i_sense.bat_above_ov [*3] |-> !o_charge_run)
    else $error("charging runs during battery overvoltage");
  rail_short_latch_a: assert property (uv_cnt_r > SCP_LIM |-> !o_converter_run)
    else $error("converter runs after long rail undervoltage");
  global_rst_stop_a: assert property (o_rst_req.global_register_reset [*3] |-> !o_charge_run)
    else $error("charging runs during global reset");
  run_resume_a: assert property ($rose(o_converter_run) |->
    !$past(i_sense.usb_above_ovp) && o_charge_run)
    else $error("converter resumed during bus overvoltage");
  otp_load_len_a: assert property (busy_cnt_r <= 8'(P_OTP_CYCLES + 1))
    else $error("load busy lasts too long");
  rst_req_bus_a: assert property ($changed(o_rst_req) |-> !i_smb_clk)
    else $error("reset request moved outside a bus write");
  data_oe_edge_a: assert property ($changed(o_smb_data_oe) |-> !i_smb_clk && !o_smb_data_out)
    else $error("data line changed while bus clock high");
endmodule : csr_regs_asserts

// ==== testbench/test_charger_status_reset_regs.sv ====
// Self-checking bench for the charger status and reset register bank.
// Drives comparator levels and a bit-banged bus master; open-drain data resolved here.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module test_charger_status_reset_regs
  import csr_pkg::*;
;
  localparam int P_TICK = 10;
  localparam int P_SCP = 250;
  localparam int P_OTP = 4;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  csr_sense_t sense = '0;
  logic usb_en = 1'b0;
  logic adp_en = 1'b1;
  logic smb_clk = 1'b1;
  logic smb_drive = 1'b1;
  wire logic smb_data;
  logic oe, dout, conv_run, chg_run, busy;
  csr_rst_req_t rst_req;
  int err_total = 0;
  int comparisons = 0;
  logic nak = 1'b0;
  logic seen_busy = 1'b0;
  logic [15:0] rd;
  assign smb_data = smb_drive & (oe ? dout : 1'b1);
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (busy) seen_busy <= 1'b1;
  end
  csr_regs #(.P_TICK_CYCLES(P_TICK), .P_SCP_TICKS(P_SCP), .P_OTP_CYCLES(P_OTP)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sense(sense),
    .i_usb_bus_input_enable(usb_en), .i_adapter_input_enable(adp_en),
    .i_smb_clk(smb_clk), .i_smb_data(smb_data), .o_smb_data_out(dout),
    .o_smb_data_oe(oe), .o_converter_run(conv_run), .o_charge_run(chg_run),
    .o_otp_load_busy(busy), .o_rst_req(rst_req));
  function automatic logic [15:0] exp_input(csr_sense_t s, logic ue, logic ae);
    logic [15:0] v;
    v = '0;
    v[CSR_B_SENSE_DET] = s.sense_above_uvlo;
    v[CSR_B_ADP_OVP] = ae ? s.adapter_above_ovp : (!ue && s.sense_above_ovp);
    v[CSR_B_ADP_CLPS] = ae ? s.adapter_clps : (!ue && s.sense_clps);
    v[CSR_B_ADP_DET] = s.adapter_above_uvlo;
    v[CSR_B_USB_OVP] = s.usb_above_ovp;
    v[CSR_B_USB_CLPS] = s.usb_clps;
    v[CSR_B_USB_DET] = s.usb_above_uvlo;
    return v;
  endfunction : exp_input
  function automatic logic exp_run(csr_sense_t s, logic ue, logic ae);
    return !(s.usb_above_ovp || s.bat_above_ov ||
      (ae ? s.adapter_above_ovp : (!ue && s.sense_above_ovp)));
  endfunction : exp_run
  function automatic logic [15:0] exp_rail(csr_sense_t s, logic run, logic scp);
    logic [15:0] v;
    v = '0;
    v[CSR_B_SYS_OV] = (s.sys_above_ovp && !s.usb_above_uvlo && !s.adapter_above_uvlo) || scp;
    v[CSR_B_SYS_SSD] = s.softstart_done && run;
    v[CSR_B_SYS_SCP] = scp;
    v[CSR_B_SYS_UV] = s.sys_below_uvlo;
    v[CSR_B_BAT_OV] = s.bat_above_ov;
    v[CSR_B_DEPLETED] = s.bat_below_sysreg;
    return v;
  endfunction : exp_rail
  // Six cycles a phase keeps clear of the slave's pin synchronisers
  task automatic half();
    repeat (6) @(negedge i_clk);
  endtask : half
  task automatic bstart();
    smb_drive = 1'b1;
    half();
    smb_clk = 1'b1;
    half();
    smb_drive = 1'b0;
    half();
    smb_clk = 1'b0;
    half();
  endtask : bstart
  task automatic bstop();
    smb_drive = 1'b0;
    half();
    smb_clk = 1'b1;
    half();
    smb_drive = 1'b1;
    half();
  endtask : bstop
  task automatic xbit(input logic b, output logic r);
    smb_drive = b;
    half();
    smb_clk = 1'b1;
    half();
    r = smb_data;
    smb_clk = 1'b0;
    half();
  endtask : xbit
  task automatic xbyte(input logic [7:0] v, input logic rdb, input logic last,
                       output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(v[i], r[i]);
    xbit(last, a);
    if (!rdb) nak |= a;
  endtask : xbyte
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    logic [7:0] r;
    nak = 1'b0;
    bstart();
    xbyte({CSR_DEV_ADDR, 1'b0}, 1'b0, 1'b1, r);
    xbyte(off, 1'b0, 1'b1, r);
    xbyte(d[7:0], 1'b0, 1'b1, r);
    xbyte(d[15:8], 1'b0, 1'b1, r);
    bstop();
    `CHK(nak, 1'b0)
  endtask : wr
  task automatic chk_reg(input logic [7:0] off, input logic [15:0] e);
    logic [7:0] r;
    nak = 1'b0;
    bstart();
    xbyte({CSR_DEV_ADDR, 1'b0}, 1'b0, 1'b1, r);
    xbyte(off, 1'b0, 1'b1, r);
    bstart();
    xbyte({CSR_DEV_ADDR, 1'b1}, 1'b0, 1'b1, r);
    xbyte(8'hff, 1'b1, 1'b0, rd[7:0]);
    xbyte(8'hff, 1'b1, 1'b1, rd[15:8]);
    bstop();
    `CHK({nak, rd}, {1'b0, e})
  endtask : chk_reg
  task automatic tdone(input string n);
    $display("test %s finished, mismatches so far %0d", n, err_total);
  endtask : tdone
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    logic [7:0] r;
    int bits[4];
    bits = '{6, 5, 4, 0};
    void'($urandom(32'h2d10ad43));
    repeat (12) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (P_OTP + 4) @(negedge i_clk);
    chk_reg(CSR_OFF_SYS_CTRL, CSR_CTRL_RESET);
    chk_reg(CSR_OFF_SYS_STATUS, 16'h0002);
    chk_reg(CSR_OFF_WATCH, CSR_WATCH_RESET);
    chk_reg(8'h77, 16'h0000);
    wr(CSR_OFF_INPUT, 16'hffff);
    chk_reg(CSR_OFF_INPUT, exp_input(sense, usb_en, adp_en));
    nak = 1'b0;
    bstart();
    xbyte({CSR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, 1'b1, r);
    bstop();
    `CHK(nak, 1'b1)
    tdone("reset_and_access");
    for (int i = 0; i < 10; i++) begin
      sense = 18'($urandom);
      sense.adapter_limit_mod = 1'b0;
      sense.usb_limit_mod = 1'b0;
      sense.bat_short_cmp = 1'b0;
      // Odd passes only, so the low rail never lasts the short-circuit window
      sense.sys_below_uvlo &= i[0];
      sense.bat_below_ov_hyst = !sense.bat_above_ov;
      adp_en = (i < 2) ? 1'b0 : 1'($urandom);
      usb_en = (i < 2) ? 1'b0 : 1'($urandom);
      repeat (4) @(negedge i_clk);
      `CHK(conv_run, exp_run(sense, usb_en, adp_en))
      chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, exp_run(sense, usb_en, adp_en), 1'b0));
      chk_reg(CSR_OFF_INPUT, exp_input(sense, usb_en, adp_en));
    end
    tdone("random_flags");
    sense = '0;
    adp_en = 1'b1;
    sense.usb_above_uvlo = 1'b1;
    sense.adapter_above_uvlo = 1'b1;
    sense.bat_below_ov_hyst = 1'b1;
    foreach (bits[j]) begin
      wr(CSR_OFF_SYS_CTRL, 16'h0001 << bits[j]);
      `CHK(rst_req, {bits[j] == 6, bits[j] == 5, bits[j] == 4, bits[j] == 0})
      `CHK(conv_run, bits[j] != 0)
      chk_reg(CSR_OFF_SYS_STATUS, (16'h0001 << bits[j]) | 16'h0002);
      chk_reg(CSR_OFF_INPUT, (bits[j] == 4 || bits[j] == 0) ? 16'h0 : 16'h0101);
      wr(CSR_OFF_SYS_CTRL, 16'h0000);
      `CHK(rst_req, 4'h0)
    end
    seen_busy = 1'b0;
    wr(CSR_OFF_SYS_CTRL, 16'h0002);
    `CHK(seen_busy, 1'b1)
    chk_reg(CSR_OFF_SYS_CTRL, 16'h0000);
    chk_reg(CSR_OFF_SYS_STATUS, 16'h0002);
    chk_reg(CSR_OFF_CHGOP, 16'h0002);
    tdone("control_resets");
    sense.sys_below_uvlo = 1'b1;
    repeat (P_TICK * (P_SCP + 1) + 20) @(negedge i_clk);
    `CHK(conv_run, 1'b0)
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b0, 1'b1));
    sense.sys_below_uvlo = 1'b0;
    repeat (8) @(negedge i_clk);
    `CHK(conv_run, 1'b0)
    sense.usb_above_uvlo = 1'b0;
    sense.adapter_above_uvlo = 1'b0;
    repeat (8) @(negedge i_clk);
    sense.usb_above_uvlo = 1'b1;
    repeat (8) @(negedge i_clk);
    `CHK(conv_run, 1'b1)
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b1, 1'b0));
    tdone("rail_short");
    wr(CSR_OFF_WATCH, 16'h0300);
    chk_reg(CSR_OFF_WATCH, 16'h0300);
    sense.bat_short_cmp = 1'b1;
    repeat (25) @(negedge i_clk);
    sense.bat_short_cmp = 1'b0;
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b1, 1'b0));
    sense.bat_short_cmp = 1'b1;
    sense.adapter_limit_mod = 1'b1;
    sense.usb_limit_mod = 1'b1;
    repeat (60) @(negedge i_clk);
    `CHK(conv_run, 1'b1)
    sense.bat_short_cmp = 1'b0;
    sense.adapter_limit_mod = 1'b0;
    sense.usb_limit_mod = 1'b0;
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b1, 1'b0) | 16'h0040);
    chk_reg(CSR_OFF_INPUT, exp_input(sense, usb_en, adp_en) | 16'h0404);
    wr(CSR_OFF_SYS_CTRL, 16'h0020);
    wr(CSR_OFF_SYS_CTRL, 16'h0000);
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b1, 1'b0));
    chk_reg(CSR_OFF_INPUT, exp_input(sense, usb_en, adp_en));
    tdone("sticky_flags");
    sense.bat_above_ov = 1'b1;
    sense.bat_below_ov_hyst = 1'b0;
    repeat (4) @(negedge i_clk);
    sense.bat_above_ov = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK(conv_run, 1'b0)
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b0, 1'b0) | 16'h0008);
    sense.bat_below_ov_hyst = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHK(conv_run, 1'b1)
    chk_reg(CSR_OFF_BAT_RAIL, exp_rail(sense, 1'b1, 1'b0));
    tdone("battery_overvoltage");
    final_report();
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    err_total++;
    final_report();
  end
endmodule : test_charger_status_reset_regs
bind csr_regs csr_regs_asserts #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_SCP_TICKS(P_SCP_TICKS),
  .P_OTP_CYCLES(P_OTP_CYCLES)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_sense(i_sense), .i_usb_bus_input_enable(i_usb_bus_input_enable),
  .i_adapter_input_enable(i_adapter_input_enable), .i_smb_clk(i_smb_clk),
  .i_smb_data(i_smb_data), .o_smb_data_out(o_smb_data_out), .o_smb_data_oe(o_smb_data_oe),
  .o_converter_run(o_converter_run), .o_charge_run(o_charge_run),
  .o_otp_load_busy(o_otp_load_busy), .o_rst_req(o_rst_req));
